// ==== src/adcrc_top.sv ====
// adcrc_top: result, calibration and bias registers on an apb slave
`timescale 1ns/1ps
module adcrc_top #(
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // converter core side
  input  wire logic        os_done_i,
  input  wire logic [31:0] os_result_i,
  input  wire logic        sq_done_i,
  input  wire logic [31:0] sq_result_i,
  // factory trim, sampled at reset release
  input  wire logic [6:0]  fac_sq_gain_i,
  input  wire logic [6:0]  fac_sq_ofs_i,
  input  wire logic [6:0]  fac_os_gain_i,
  input  wire logic [6:0]  fac_os_ofs_i,
  // trim and bias to the analog core
  output logic      [6:0]  sq_gain_trim_o,
  output logic      [6:0]  sq_offset_trim_o,
  output logic      [6:0]  os_gain_trim_o,
  output logic      [6:0]  os_offset_trim_o,
  output logic      [3:0]  current_level_o,
  output logic             halve_current_o,
  output logic      [3:0]  comparator_current_o,
  // status, dma and interrupt
  output logic             os_data_valid_o,
  output logic             sq_data_valid_o,
  output logic             os_dma_req_o,
  output logic             sq_dma_req_o,
  output logic             irq_o
);
  initial begin
    if (DW != 32) $error("adcrc_top: DW must be 32");
  end

  // ***************************************************************
  // bus decode
  // ***************************************************************
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [31:0] rd_val;
  logic [31:0] os_res_r;
  logic [31:0] sq_res_r;
  logic [31:0] ien_r;
  logic [3:0]  flags;
  logic [3:0]  f_set;
  logic [3:0]  f_clr;
  logic        trim_load_r;
  logic        os_ovf;
  logic        sq_ovf;

  // single-cycle access phase, no wait states
  assign pready_o = 1'b1;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // unmapped words answer with an error
  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      adcrc_pkg::ADDR_IEN_OFS, adcrc_pkg::ADDR_IF_OFS,
      adcrc_pkg::ADDR_IFS_OFS, adcrc_pkg::ADDR_IFC_OFS,
      adcrc_pkg::ADDR_OS_RES,  adcrc_pkg::ADDR_SQ_RES,
      adcrc_pkg::ADDR_OS_PEEK, adcrc_pkg::ADDR_SQ_PEEK,
      adcrc_pkg::ADDR_CAL,     adcrc_pkg::ADDR_BIAS,
      adcrc_pkg::ADDR_STATE:   mapped = 1'b1;
      default:                 mapped = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ***************************************************************
  // results and data valid
  // ***************************************************************
  // latest results; a fresh result overwrites the old one
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      os_res_r <= adcrc_pkg::RESULT_RST;
      sq_res_r <= adcrc_pkg::RESULT_RST;
    end else begin
      if (os_done_i) os_res_r <= os_result_i;
      if (sq_done_i) sq_res_r <= sq_result_i;
    end
  end

  // overflow: new result while the old one is still unread
  assign os_ovf = os_done_i && os_data_valid_o;
  assign sq_ovf = sq_done_i && sq_data_valid_o;

  // valid and dma request; set wins over the clearing read
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      os_data_valid_o <= 1'b0;
      sq_data_valid_o <= 1'b0;
    end else begin
      if (os_done_i) begin
        os_data_valid_o <= 1'b1;
      end else if (rd_en && hit(paddr_i, adcrc_pkg::ADDR_OS_RES)) begin
        os_data_valid_o <= 1'b0;
      end
      if (sq_done_i) begin
        sq_data_valid_o <= 1'b1;
      end else if (rd_en && hit(paddr_i, adcrc_pkg::ADDR_SQ_RES)) begin
        sq_data_valid_o <= 1'b0;
      end
    end
  end
  // dma wants data while it is unread; a peek does not retire it
  assign os_dma_req_o = os_data_valid_o;
  assign sq_dma_req_o = sq_data_valid_o;

  // ***************************************************************
  // calibration trim
  // ***************************************************************
  // factory trims arrive on pins; caught on the first edge after release
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      trim_load_r <= 1'b1;
    end else begin
      trim_load_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sq_gain_trim_o   <= adcrc_pkg::GAIN_RST;
      sq_offset_trim_o <= adcrc_pkg::OFS_RST;
      os_gain_trim_o   <= adcrc_pkg::GAIN_RST;
      os_offset_trim_o <= adcrc_pkg::OFS_RST;
    end else if (trim_load_r) begin
      sq_gain_trim_o   <= fac_sq_gain_i;
      sq_offset_trim_o <= fac_sq_ofs_i;
      os_gain_trim_o   <= fac_os_gain_i;
      os_offset_trim_o <= fac_os_ofs_i;
    end else if (wr_en && hit(paddr_i, adcrc_pkg::ADDR_CAL)) begin
      // reserved bits 31, 23, 15, 7 dropped
      sq_gain_trim_o   <= pwdata_i[adcrc_pkg::SQ_GAIN_LSB +: 7];
      sq_offset_trim_o <= pwdata_i[adcrc_pkg::SQ_OFS_LSB +: 7];
      os_gain_trim_o   <= pwdata_i[adcrc_pkg::OS_GAIN_LSB +: 7];
      os_offset_trim_o <= pwdata_i[adcrc_pkg::OS_OFS_LSB +: 7];
    end
  end

  // ***************************************************************
  // bias programming
  // ***************************************************************
  // analog core reads the fields; halving is done in the current mirror
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      current_level_o      <= adcrc_pkg::BIAS_RST;
      halve_current_o      <= adcrc_pkg::HALF_RST;
      comparator_current_o <= adcrc_pkg::BIAS_RST;
    end else if (wr_en && hit(paddr_i, adcrc_pkg::ADDR_BIAS)) begin
      current_level_o <= pwdata_i[adcrc_pkg::BIAS_LVL_LSB +: 4];
      halve_current_o <= pwdata_i[adcrc_pkg::BIAS_HALF_BIT];
      comparator_current_o <=
        pwdata_i[adcrc_pkg::BIAS_CMP_LSB +: 4];
    end
  end

  // ***************************************************************
  // interrupts
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ien_r <= 32'h0000_0000;
    end else if (wr_en && hit(paddr_i, adcrc_pkg::ADDR_IEN_OFS)) begin
      ien_r <= pwdata_i & adcrc_pkg::FLAG_MASK;
    end
  end

  // flag vector order: os done, sq done, os overflow, sq overflow
  always_comb begin
    f_set = 4'h0;
    f_clr = 4'h0;
    if (wr_en && hit(paddr_i, adcrc_pkg::ADDR_IFS_OFS)) begin
      f_set = {pwdata_i[adcrc_pkg::FLAG_SQ_OVF],
               pwdata_i[adcrc_pkg::FLAG_OS_OVF],
               pwdata_i[adcrc_pkg::FLAG_SQ_DONE],
               pwdata_i[adcrc_pkg::FLAG_OS_DONE]};
    end
    if (wr_en && hit(paddr_i, adcrc_pkg::ADDR_IFC_OFS)) begin
      f_clr = {pwdata_i[adcrc_pkg::FLAG_SQ_OVF],
               pwdata_i[adcrc_pkg::FLAG_OS_OVF],
               pwdata_i[adcrc_pkg::FLAG_SQ_DONE],
               pwdata_i[adcrc_pkg::FLAG_OS_DONE]};
    end
  end

  adcrc_flags #(
    .NF (4)
  ) u_flags (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .event_i   ({sq_ovf, os_ovf, sq_done_i, os_done_i}),
    .set_i     (f_set),
    .clr_i     (f_clr),
    .mask_i    ({ien_r[adcrc_pkg::FLAG_SQ_OVF],
                 ien_r[adcrc_pkg::FLAG_OS_OVF],
                 ien_r[adcrc_pkg::FLAG_SQ_DONE],
                 ien_r[adcrc_pkg::FLAG_OS_DONE]}),
    .flags_o   (flags),
    .irq_o     (irq_o)
  );

  // ***************************************************************
  // read mux
  // ***************************************************************
  // reserved bits read as zero, so ignoring them is safe
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr_i)
      adcrc_pkg::ADDR_IEN_OFS: rd_val = ien_r;
      adcrc_pkg::ADDR_IF_OFS: begin
        rd_val[adcrc_pkg::FLAG_OS_DONE] = flags[0];
        rd_val[adcrc_pkg::FLAG_SQ_DONE] = flags[1];
        rd_val[adcrc_pkg::FLAG_OS_OVF]  = flags[2];
        rd_val[adcrc_pkg::FLAG_SQ_OVF]  = flags[3];
      end
      adcrc_pkg::ADDR_OS_RES:  rd_val = os_res_r;
      adcrc_pkg::ADDR_SQ_RES:  rd_val = sq_res_r;
      adcrc_pkg::ADDR_OS_PEEK: rd_val = os_res_r;
      adcrc_pkg::ADDR_SQ_PEEK: rd_val = sq_res_r;
      adcrc_pkg::ADDR_CAL: begin
        rd_val[adcrc_pkg::SQ_GAIN_LSB +: 7] = sq_gain_trim_o;
        rd_val[adcrc_pkg::SQ_OFS_LSB +: 7]  = sq_offset_trim_o;
        rd_val[adcrc_pkg::OS_GAIN_LSB +: 7] = os_gain_trim_o;
        rd_val[adcrc_pkg::OS_OFS_LSB +: 7]  = os_offset_trim_o;
      end
      adcrc_pkg::ADDR_BIAS: begin
        rd_val[adcrc_pkg::BIAS_LVL_LSB +: 4] = current_level_o;
        rd_val[adcrc_pkg::BIAS_HALF_BIT]     = halve_current_o;
        rd_val[adcrc_pkg::BIAS_CMP_LSB +: 4] = comparator_current_o;
      end
      adcrc_pkg::ADDR_STATE: begin
        rd_val[adcrc_pkg::ST_OS_DV]  = os_data_valid_o;
        rd_val[adcrc_pkg::ST_SQ_DV]  = sq_data_valid_o;
        rd_val[adcrc_pkg::ST_OS_DMA] = os_dma_req_o;
        rd_val[adcrc_pkg::ST_SQ_DMA] = sq_dma_req_o;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_val;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_os_read_clears;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_en && paddr_i == adcrc_pkg::ADDR_OS_RES && !os_done_i)
        |=> !os_data_valid_o;
  endproperty
  a_os_read_clears: assert property (p_os_read_clears)
    else $error("one-shot read did not clear valid");

  property p_sq_read_clears;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_en && paddr_i == adcrc_pkg::ADDR_SQ_RES && !sq_done_i)
        |=> !sq_data_valid_o;
  endproperty
  a_sq_read_clears: assert property (p_sq_read_clears)
    else $error("sequence read did not clear valid");

  property p_os_peek_keeps;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_en && paddr_i == adcrc_pkg::ADDR_OS_PEEK && os_dma_req_o)
        |=> (os_data_valid_o && os_dma_req_o);
  endproperty
  a_os_peek_keeps: assert property (p_os_peek_keeps)
    else $error("one-shot peek disturbed valid or dma");

  property p_sq_peek_keeps;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_en && paddr_i == adcrc_pkg::ADDR_SQ_PEEK && sq_data_valid_o)
        |=> sq_data_valid_o;
  endproperty
  a_sq_peek_keeps: assert property (p_sq_peek_keeps)
    else $error("sequence peek cleared valid");

  property p_cal_write;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_en && paddr_i == adcrc_pkg::ADDR_CAL && !trim_load_r)
        |=> (sq_gain_trim_o == $past(pwdata_i[30:24])
             && sq_offset_trim_o == $past(pwdata_i[22:16])
             && os_offset_trim_o == $past(pwdata_i[6:0]));
  endproperty
  a_cal_write: assert property (p_cal_write)
    else $error("calibration write not stored");

  property p_bias_reset;
    @(posedge clk_sys_i)
      !reset_n_i |=> (current_level_o == 4'h7 && halve_current_o
                      && comparator_current_o == 4'h7);
  endproperty
  a_bias_reset: assert property (p_bias_reset)
    else $error("bias reset value wrong");

  property p_bias_write;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_en && paddr_i == adcrc_pkg::ADDR_BIAS)
        |=> (halve_current_o == $past(pwdata_i[6])
             && comparator_current_o == $past(pwdata_i[11:8]));
  endproperty
  a_bias_write: assert property (p_bias_write)
    else $error("bias write not stored");

  property p_trim_load;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      trim_load_r |=> (os_gain_trim_o == $past(fac_os_gain_i));
  endproperty
  a_trim_load: assert property (p_trim_load)
    else $error("factory gain trim not loaded");

  c_os_read: cover property (@(posedge clk_sys_i)
    os_done_i ##[1:20] (rd_en && paddr_i == adcrc_pkg::ADDR_OS_RES));
  c_sq_peek: cover property (@(posedge clk_sys_i)
    sq_done_i ##[1:20] (rd_en && paddr_i == adcrc_pkg::ADDR_SQ_PEEK));
  c_irq: cover property (@(posedge clk_sys_i) irq_o);
endmodule

// ==== shared/adcrc_pkg.sv ====
// adcrc_pkg: constants for the converter result and calibration registers
package adcrc_pkg;
  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_IEN_OFS   = 8'h14;
  localparam logic [7:0] ADDR_IF_OFS    = 8'h18;
  localparam logic [7:0] ADDR_IFS_OFS   = 8'h1c;
  localparam logic [7:0] ADDR_IFC_OFS   = 8'h20;
  localparam logic [7:0] ADDR_OS_RES    = 8'h24;
  localparam logic [7:0] ADDR_SQ_RES    = 8'h28;
  localparam logic [7:0] ADDR_OS_PEEK   = 8'h2c;
  localparam logic [7:0] ADDR_SQ_PEEK   = 8'h30;
  localparam logic [7:0] ADDR_CAL       = 8'h34;
  localparam logic [7:0] ADDR_BIAS      = 8'h3c;
  localparam logic [7:0] ADDR_STATE     = 8'h40;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int FLAG_OS_DONE  = 0;
  localparam int FLAG_SQ_DONE  = 1;
  localparam int FLAG_OS_OVF   = 8;
  localparam int FLAG_SQ_OVF   = 9;
  localparam logic [31:0] FLAG_MASK = 32'h0000_0303;
  localparam int SQ_GAIN_LSB   = 24;
  localparam int SQ_OFS_LSB    = 16;
  localparam int OS_GAIN_LSB   = 8;
  localparam int OS_OFS_LSB    = 0;
  localparam int TRIM_W        = 7;
  localparam int BIAS_LVL_LSB  = 0;
  localparam int BIAS_HALF_BIT = 6;
  localparam int BIAS_CMP_LSB  = 8;
  localparam int BIAS_W        = 4;
  localparam int ST_OS_DV      = 0;
  localparam int ST_SQ_DV      = 1;
  localparam int ST_OS_DMA     = 2;
  localparam int ST_SQ_DMA     = 3;
  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [6:0]  GAIN_RST   = 7'h3f;
  localparam logic [6:0]  OFS_RST    = 7'h00;
  localparam logic [3:0]  BIAS_RST   = 4'h7;
  localparam logic        HALF_RST   = 1'h1;
endpackage

// ==== src/adcrc_flags.sv ====
// adcrc_flags: sticky event flags with mask and one interrupt line
`timescale 1ns/1ps
module adcrc_flags #(
  parameter int NF = 4
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          reset_n_i,
  // events and software strobes
  input  wire logic [NF-1:0] event_i,
  input  wire logic [NF-1:0] set_i,
  input  wire logic [NF-1:0] clr_i,
  input  wire logic [NF-1:0] mask_i,
  // state
  output logic      [NF-1:0] flags_o,
  output logic               irq_o
);
  initial begin
    if (NF < 1) $error("adcrc_flags: NF must be at least one");
  end

  // set beats clear so an event in the clear cycle is kept
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~clr_i) | event_i | set_i;
    end
  end

  // level interrupt, high while any unmasked flag stands
  assign irq_o = |(flags_o & mask_i);

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_clr_flag;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (clr_i[0] && !event_i[0] && !set_i[0]) |=> !flags_o[0];
  endproperty
  a_clr_flag: assert property (p_clr_flag)
    else $error("done flag not cleared by write of one");

  property p_keep_flag;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (flags_o[0] && !clr_i[0]) |=> flags_o[0];
  endproperty
  a_keep_flag: assert property (p_keep_flag)
    else $error("done flag lost without a clear");

  property p_set_wins;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (event_i[0] && clr_i[0]) |=> flags_o[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in clear cycle");

  c_clear_hit: cover property (@(posedge clk_sys_i)
    flags_o[0] ##1 clr_i[0] ##1 !flags_o[0]);
endmodule

// ==== verif/adcrc_core_model.sv ====
// adcrc_core_model: converter core stand-in with factory trim levels
`timescale 1ns/1ps
module adcrc_core_model #(
  // factory trims, distinct from the reset constants on purpose
  parameter logic [6:0] FAC_SQ_GAIN = 7'h35,
  parameter logic [6:0] FAC_SQ_OFS  = 7'h7e,
  parameter logic [6:0] FAC_OS_GAIN = 7'h2a,
  parameter logic [6:0] FAC_OS_OFS  = 7'h01
) (
  // clock
  input  wire logic        clk_sys_i,
  // result strobes
  output logic             os_done_o,
  output logic      [31:0] os_result_o,
  output logic             sq_done_o,
  output logic      [31:0] sq_result_o,
  // factory trim levels
  output logic      [6:0]  fac_sq_gain_o,
  output logic      [6:0]  fac_sq_ofs_o,
  output logic      [6:0]  fac_os_gain_o,
  output logic      [6:0]  fac_os_ofs_o
);
  // trims are fixed fuses
  assign fac_sq_gain_o = FAC_SQ_GAIN;
  assign fac_sq_ofs_o  = FAC_SQ_OFS;
  assign fac_os_gain_o = FAC_OS_GAIN;
  assign fac_os_ofs_o  = FAC_OS_OFS;
  // idle buses
  initial begin
    os_done_o   = 1'b0;
    sq_done_o   = 1'b0;
    os_result_o = 32'h0000_0000;
    sq_result_o = 32'h0000_0000;
  end
  // one-cycle done pulse; result is scrambled after it so a late latch shows
  task automatic convert(input logic seq, input logic [31:0] val);
    @(posedge clk_sys_i);
    if (seq) begin
      sq_done_o   <= 1'b1;
      sq_result_o <= val;
    end else begin
      os_done_o   <= 1'b1;
      os_result_o <= val;
    end
    @(posedge clk_sys_i);
    os_done_o   <= 1'b0;
    sq_done_o   <= 1'b0;
    os_result_o <= ~val;
    sq_result_o <= ~val;
    @(negedge clk_sys_i);
  endtask
endmodule

// ==== verif/adcrc_top_test.sv ====
// adcrc_top_test: apb driven regression of result, trim and bias registers
`timescale 1ns/1ps
module adcrc_top_test;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, os_done_i, sq_done_i, irq_o;
  logic [31:0] os_result_i, sq_result_i;
  logic [6:0]  fsg, fso, fog, foo, sg_o, so_o, og_o, oo_o;
  logic [3:0]  lvl_o, cmp_o;
  logic        half_o, osv_o, sqv_o, osd_o, sqd_o;
  int          mismatches = 0;
  int          checks_done = 0;
  logic [31:0] rd;
  logic        er;
  localparam logic [31:0] CAL_FAC = 32'h357e_2a01;
  localparam logic [31:0] TRIM_RST =
    {18'h0, adcrc_pkg::GAIN_RST, adcrc_pkg::OFS_RST};
  // 40 MHz clock
  always #12.5 clk_sys_i = ~clk_sys_i;
  adcrc_core_model core_u (.clk_sys_i(clk_sys_i), .os_done_o(os_done_i),
    .os_result_o(os_result_i), .sq_done_o(sq_done_i),
    .sq_result_o(sq_result_i), .fac_sq_gain_o(fsg), .fac_sq_ofs_o(fso),
    .fac_os_gain_o(fog), .fac_os_ofs_o(foo));
  adcrc_top dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .os_done_i(os_done_i),
    .os_result_i(os_result_i), .sq_done_i(sq_done_i),
    .sq_result_i(sq_result_i), .fac_sq_gain_i(fsg), .fac_sq_ofs_i(fso),
    .fac_os_gain_i(fog), .fac_os_ofs_i(foo), .sq_gain_trim_o(sg_o),
    .sq_offset_trim_o(so_o), .os_gain_trim_o(og_o),
    .os_offset_trim_o(oo_o), .current_level_o(lvl_o),
    .halve_current_o(half_o), .comparator_current_o(cmp_o),
    .os_data_valid_o(osv_o), .sq_data_valid_o(sqv_o),
    .os_dma_req_o(osd_o), .sq_dma_req_o(sqd_o), .irq_o(irq_o));
  // ***************************************************************
  // compare, bus and closing tasks
  // ***************************************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 64);
    if (n >= 64) mismatches++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rd, exp);
    chk_bit(er, 1'b0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #(25 * 20000);
    mismatches++;
    test_done();
  end
  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk_word({18'h0, sg_o, oo_o}, TRIM_RST);
    // release on a rising edge, after the fourth reset cycle
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    // reset contents
    rd_chk(adcrc_pkg::ADDR_OS_RES, 32'h0000_0000);
    rd_chk(adcrc_pkg::ADDR_SQ_RES, 32'h0000_0000);
    rd_chk(adcrc_pkg::ADDR_OS_PEEK, 32'h0000_0000);
    rd_chk(adcrc_pkg::ADDR_SQ_PEEK, 32'h0000_0000);
    rd_chk(adcrc_pkg::ADDR_CAL, CAL_FAC);
    rd_chk(adcrc_pkg::ADDR_BIAS, 32'h0000_0747);
    chk_word({23'h0, cmp_o, half_o, lvl_o}, 32'h0000_00f7);
    apb(1'b0, 8'h38, 32'h0000_0000);
    chk_word({31'h0, er}, 32'h0000_0001);
    chk_word(rd, 32'h0000_0000);
    $display("test reset done");
    // one-shot result, peek, read clear and done interrupt
    apb(1'b1, adcrc_pkg::ADDR_IEN_OFS, 32'h0000_0001);
    core_u.convert(1'b0, 32'h8badf00d);
    chk_word({30'h0, osd_o, osv_o}, 32'h0000_0003);
    chk_bit(irq_o, 1'b1);
    rd_chk(adcrc_pkg::ADDR_OS_PEEK, 32'h8badf00d);
    chk_word({30'h0, osd_o, osv_o}, 32'h0000_0003);
    rd_chk(adcrc_pkg::ADDR_OS_RES, 32'h8badf00d);
    chk_word({30'h0, osd_o, osv_o}, 32'h0000_0000);
    apb(1'b1, adcrc_pkg::ADDR_IFC_OFS, 32'h0000_0000);
    chk_bit(irq_o, 1'b1);
    apb(1'b1, adcrc_pkg::ADDR_IEN_OFS, 32'h0000_0000);
    chk_bit(irq_o, 1'b0);
    apb(1'b1, adcrc_pkg::ADDR_IEN_OFS, 32'h0000_0001);
    apb(1'b1, adcrc_pkg::ADDR_IFC_OFS, 32'h0000_0001);
    chk_bit(irq_o, 1'b0);
    rd_chk(adcrc_pkg::ADDR_IF_OFS, 32'h0000_0000);
    $display("test one_shot done");
    // sequence result, peek keeps valid, read clears it
    core_u.convert(1'b1, 32'h0001_f00f);
    chk_word({30'h0, sqd_o, sqv_o}, 32'h0000_0003);
    rd_chk(adcrc_pkg::ADDR_STATE, 32'h0000_000a);
    rd_chk(adcrc_pkg::ADDR_SQ_PEEK, 32'h0001_f00f);
    chk_bit(sqv_o, 1'b1);
    rd_chk(adcrc_pkg::ADDR_SQ_RES, 32'h0001_f00f);
    chk_bit(sqv_o, 1'b0);
    rd_chk(adcrc_pkg::ADDR_OS_RES, 32'h8badf00d);
    // second unread result raises overflow; flag set and clear by software
    core_u.convert(1'b1, 32'h0000_0123);
    core_u.convert(1'b1, 32'h0000_0456);
    rd_chk(adcrc_pkg::ADDR_IF_OFS, 32'h0000_0202);
    apb(1'b1, adcrc_pkg::ADDR_IFS_OFS, 32'h0000_0101);
    rd_chk(adcrc_pkg::ADDR_IF_OFS, 32'h0000_0303);
    apb(1'b1, adcrc_pkg::ADDR_IFC_OFS, 32'h0000_0303);
    rd_chk(adcrc_pkg::ADDR_IF_OFS, 32'h0000_0000);
    rd_chk(adcrc_pkg::ADDR_SQ_RES, 32'h0000_0456);
    $display("test sequence done");
    // trims: every field to all ones, then a mixed pattern
    apb(1'b1, adcrc_pkg::ADDR_CAL, 32'h7f7f_7f7f);
    rd_chk(adcrc_pkg::ADDR_CAL, 32'h7f7f_7f7f);
    apb(1'b1, adcrc_pkg::ADDR_CAL, 32'h4a13_2c55);
    rd_chk(adcrc_pkg::ADDR_CAL, 32'h4a13_2c55);
    chk_word({4'h0, sg_o, so_o, og_o, oo_o}, 32'h0944_d655);
    $display("test trim done");
    // bias: all ones then all zeros, fields and outputs
    apb(1'b1, adcrc_pkg::ADDR_BIAS, 32'h0000_0f4f);
    rd_chk(adcrc_pkg::ADDR_BIAS, 32'h0000_0f4f);
    chk_word({23'h0, cmp_o, half_o, lvl_o}, 32'h0000_01ff);
    apb(1'b1, adcrc_pkg::ADDR_BIAS, 32'h0000_0000);
    rd_chk(adcrc_pkg::ADDR_BIAS, 32'h0000_0000);
    chk_word({23'h0, cmp_o, half_o, lvl_o}, 32'h0000_0000);
    $display("test bias done");
    test_done();
  end
endmodule
